//--- rtl/sxj_pkg.sv
// pin controller package: map, fields, codes, tap states.
// assumes a 32-bit port, byte offsets.
package sxj_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_LOCK = 8'h04;
    localparam logic [7:0] REG_USER = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam logic [7:0] REG_PINS = 8'h10;
    // control fields
    localparam int SEL_W = 4;
    localparam int CTRL_SEL_A_LSB = 0;
    localparam int CTRL_SEL_B_LSB = 4;
    localparam int CTRL_USER_A = 8;
    localparam int CTRL_USER_B = 9;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam int LOCK_KILL = 0;
    // user pin fields: value bits, then output enables (low drives)
    localparam int PIN_TCK = 0;
    localparam int PIN_TDI = 1;
    localparam int PIN_TDO = 2;
    localparam int PIN_TRST = 3;
    localparam int PIN_PA = 4;
    localparam int PIN_PB = 5;
    localparam int PIN_N = 6;
    localparam int USER_OE_LSB = 8;
    localparam logic [31:0] USER_RESET = 32'h0000_3f00;
    // status fields
    localparam int ST_OWNED = 0;
    localparam int ST_TAP_RESET = 1;
    localparam int ST_CHECKSUM = 2;
    localparam int ST_DEDICATED = 3;
    localparam int ST_TRST_RES = 4;
    localparam int ST_PROBE_KILL = 5;
    // instruction register
    localparam int IR_W = 4;
    localparam logic [3:0] IR_IDCODE = 4'h1;
    localparam logic [3:0] IR_CHECKSUM = 4'h2;
    localparam logic [3:0] IR_BYPASS = 4'hf;
    localparam logic [3:0] IR_CAPTURE = 4'h1;
    localparam int DR_W = 32;
    // tck cycles with tms high that always reach logic reset
    localparam int TMS_RESET_TCKS = 5;
    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR,
        TAP_EX1_DR, TAP_PA_DR, TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR,
        TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PA_IR, TAP_EX2_IR,
        TAP_UPD_IR
    } sxj_tap_state_t;
endpackage

//--- rtl/sxj_probe_if.sv
// controller to probe stage carrier.
// assumes clk_in at both ends.
`timescale 1ns/100ps
`default_nettype none
interface sxj_probe_if;
    logic [3:0] sel_a;
    logic [3:0] sel_b;
    logic user_a;
    logic user_b;
    logic kill;
    logic [1:0] user_val;
    logic [1:0] user_oe_b;
    modport ctrl (output sel_a, sel_b, user_a, user_b, kill, user_val,
        user_oe_b);
    modport stage (input sel_a, sel_b, user_a, user_b, kill, user_val,
        user_oe_b);
endinterface
`default_nettype wire

//--- rtl/sxj_sync2.sv
// two flip-flop synchroniser.
// assumes slow independent levels.
`timescale 1ns/100ps
`default_nettype none
module sxj_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic clk_in,
    input wire logic [WIDTH-1:0] d_in,
    output logic [WIDTH-1:0] q_out
);
    logic [WIDTH-1:0] meta_q;
    // first stage read only by the second
    always_ff @(posedge clk_in) begin
        meta_q <= d_in;
        q_out <= meta_q;
    end
endmodule
`default_nettype wire

//--- rtl/sxj_probe_stage.sv
// probe pin output stage.
// assumes nodes on clk_in.
`timescale 1ns/100ps
`default_nettype none
module sxj_probe_stage #(
    parameter int NODES = 16
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic [NODES-1:0] nodes_in,
    sxj_probe_if.stage pif,
    output logic pa_out,
    output logic pa_oe_b_out,
    output logic pb_out,
    output logic pb_oe_b_out
);
    // pick one node, out of range reads low
    function automatic logic pick(input logic [NODES-1:0] n,
                                  input logic [3:0] s);
        pick = (int'(s) < NODES) ? n[s] : 1'b0;
    endfunction

    // probe a: user pin when selected, else released when disabled, else node
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            pa_out <= 1'b0;
            pa_oe_b_out <= 1'b1;
        end else if (pif.user_a) begin
            pa_out <= pif.user_val[0];
            pa_oe_b_out <= pif.user_oe_b[0];
        end else if (pif.kill) begin
            pa_out <= 1'b0;
            pa_oe_b_out <= 1'b1;
        end else begin
            pa_out <= pick(nodes_in, pif.sel_a);
            pa_oe_b_out <= 1'b0;
        end
    end

    // probe b: same choices, own select
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            pb_out <= 1'b0;
            pb_oe_b_out <= 1'b1;
        end else if (pif.user_b) begin
            pb_out <= pif.user_val[1];
            pb_oe_b_out <= pif.user_oe_b[1];
        end else if (pif.kill) begin
            pb_out <= 1'b0;
            pb_oe_b_out <= 1'b1;
        end else begin
            pb_out <= pick(nodes_in, pif.sel_b);
            pb_oe_b_out <= 1'b0;
        end
    end
endmodule
`default_nettype wire

//--- rtl/sxj_pin_ctrl.sv
// shared test pin controller: tap on tck_in,
// pin ownership, trst, checksum tdo, probes,
// register port on clk_in.
// assumes tms/tdi timed to tck_in, static
// straps, pads resolved outside.
`timescale 1ns/100ps
`default_nettype none
module sxj_pin_ctrl #(
    parameter int NODES = 16,
    parameter logic [31:0] ID_VALUE = 32'h0000_0001, // arbitrary value
    parameter logic [31:0] CHECKSUM_VALUE = 32'h0000_a5a5
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic tck_in,
    input wire logic tms_in,
    input wire logic tdi_in,
    input wire logic tdo_in,
    input wire logic trst_in,
    input wire logic dedicated_mode_in,
    input wire logic trst_reserve_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [NODES-1:0] probe_nodes_in,
    output logic [31:0] reg_rdata_out,
    output logic tck_out,
    output logic tck_oe_b_out,
    output logic tdi_out,
    output logic tdi_oe_b_out,
    output logic tdo_out,
    output logic tdo_oe_b_out,
    output logic trst_out,
    output logic trst_oe_b_out,
    output logic trst_pullup_out,
    output logic probe_out_a_out,
    output logic probe_out_a_oe_b_out,
    output logic probe_out_b_out,
    output logic probe_out_b_oe_b_out,
    output logic pins_owned_out
);
    sxj_pkg::sxj_tap_state_t tap_q;
    logic [3:0] ir_q;
    logic [3:0] ir_sh_q;
    logic [31:0] dr_sh_q;
    logic owned_t_q;
    logic [1:0] cfg_t;
    logic tck_rst_b;
    logic [1:0] user_tdo_t;
    logic tap_rst_b;
    logic cks_run;
    logic [1:0] strap_s;
    logic [3:0] pin_s;
    logic [3:0] tck_stat_s;
    logic cfg_done_q;
    logic dedicated_q;
    logic trst_res_q;
    logic own_q;
    logic [31:0] ctrl_q;
    logic kill_q;
    logic [31:0] user_q;
    sxj_probe_if pif ();

    // standard access port transitions
    function automatic sxj_pkg::sxj_tap_state_t tap_next(
        input sxj_pkg::sxj_tap_state_t s, input logic tms);
        case (s)
            sxj_pkg::TAP_RESET: tap_next = tms ? sxj_pkg::TAP_RESET
                                               : sxj_pkg::TAP_IDLE;
            sxj_pkg::TAP_IDLE: tap_next = tms ? sxj_pkg::TAP_SEL_DR
                                              : sxj_pkg::TAP_IDLE;
            sxj_pkg::TAP_SEL_DR: tap_next = tms ? sxj_pkg::TAP_SEL_IR
                                                : sxj_pkg::TAP_CAP_DR;
            sxj_pkg::TAP_CAP_DR, sxj_pkg::TAP_SH_DR:
                tap_next = tms ? sxj_pkg::TAP_EX1_DR : sxj_pkg::TAP_SH_DR;
            sxj_pkg::TAP_EX1_DR: tap_next = tms ? sxj_pkg::TAP_UPD_DR
                                                : sxj_pkg::TAP_PA_DR;
            sxj_pkg::TAP_PA_DR: tap_next = tms ? sxj_pkg::TAP_EX2_DR
                                               : sxj_pkg::TAP_PA_DR;
            sxj_pkg::TAP_EX2_DR: tap_next = tms ? sxj_pkg::TAP_UPD_DR
                                                : sxj_pkg::TAP_SH_DR;
            sxj_pkg::TAP_SEL_IR: tap_next = tms ? sxj_pkg::TAP_RESET
                                                : sxj_pkg::TAP_CAP_IR;
            sxj_pkg::TAP_CAP_IR, sxj_pkg::TAP_SH_IR:
                tap_next = tms ? sxj_pkg::TAP_EX1_IR : sxj_pkg::TAP_SH_IR;
            sxj_pkg::TAP_EX1_IR: tap_next = tms ? sxj_pkg::TAP_UPD_IR
                                                : sxj_pkg::TAP_PA_IR;
            sxj_pkg::TAP_PA_IR: tap_next = tms ? sxj_pkg::TAP_EX2_IR
                                               : sxj_pkg::TAP_PA_IR;
            sxj_pkg::TAP_EX2_IR: tap_next = tms ? sxj_pkg::TAP_UPD_IR
                                                : sxj_pkg::TAP_SH_IR;
            default: tap_next = tms ? sxj_pkg::TAP_SEL_DR
                                    : sxj_pkg::TAP_IDLE;
        endcase
    endfunction

    // tck domain
    // chip reset and straps into the tck domain
    sxj_sync2 #(.WIDTH(1)) u_rst_t (
        .clk_in(tck_in),
        .d_in(rst_b_in),
        .q_out(tck_rst_b)
    );
    sxj_sync2 #(.WIDTH(2)) u_cfg_t (
        .clk_in(tck_in),
        .d_in({trst_res_q, dedicated_q}),
        .q_out(cfg_t)
    );
    sxj_sync2 #(.WIDTH(2)) u_utdo_t (
        .clk_in(tck_in),
        .d_in({user_q[sxj_pkg::USER_OE_LSB + sxj_pkg::PIN_TDO],
               user_q[sxj_pkg::PIN_TDO]}),
        .q_out(user_tdo_t)
    );

    // trst acts only when reserved; an unreserved pin is ignored
    assign tap_rst_b = trst_in | ~cfg_t[1];

    // access port state, clocked by tck, async trst
    always_ff @(posedge tck_in or negedge tap_rst_b) begin
        if (!tap_rst_b) begin
            tap_q <= sxj_pkg::TAP_RESET;
        end else if (!tck_rst_b) begin
            tap_q <= sxj_pkg::TAP_RESET;
        end else begin
            tap_q <= tap_next(tap_q, tms_in);
        end
    end

    // instruction shift and update
    always_ff @(posedge tck_in or negedge tap_rst_b) begin
        if (!tap_rst_b) begin
            ir_q <= sxj_pkg::IR_IDCODE;
            ir_sh_q <= sxj_pkg::IR_CAPTURE;
        end else if (!tck_rst_b || tap_q == sxj_pkg::TAP_RESET) begin
            ir_q <= sxj_pkg::IR_IDCODE;
            ir_sh_q <= sxj_pkg::IR_CAPTURE;
        end else if (tap_q == sxj_pkg::TAP_CAP_IR) begin
            ir_sh_q <= sxj_pkg::IR_CAPTURE;
        end else if (tap_q == sxj_pkg::TAP_SH_IR) begin
            ir_sh_q <= {tdi_in, ir_sh_q[3:1]};
        end else if (tap_q == sxj_pkg::TAP_UPD_IR) begin
            ir_q <= ir_sh_q;
        end
    end

    // data register: id, checksum or one-bit bypass
    always_ff @(posedge tck_in) begin
        if (!tck_rst_b) begin
            dr_sh_q <= 32'h0000_0000;
        end else if (tap_q == sxj_pkg::TAP_CAP_DR) begin
            if (ir_q == sxj_pkg::IR_IDCODE) begin
                dr_sh_q <= ID_VALUE;
            end else if (ir_q == sxj_pkg::IR_CHECKSUM) begin
                dr_sh_q <= CHECKSUM_VALUE;
            end else begin
                dr_sh_q <= 32'h0000_0000;
            end
        end else if (tap_q == sxj_pkg::TAP_SH_DR) begin
            if (ir_q == sxj_pkg::IR_BYPASS) begin
                dr_sh_q <= {31'h0000_0000, tdi_in};
            end else begin
                dr_sh_q <= {tdi_in, dr_sh_q[31:1]};
            end
        end
    end

    // ownership: held in dedicated mode, else claimed on tms low, dropped at logic reset
    always_ff @(posedge tck_in or negedge tap_rst_b) begin
        if (!tap_rst_b) begin
            owned_t_q <= 1'b0;
        end else if (!tck_rst_b) begin
            owned_t_q <= 1'b0;
        end else if (cfg_t[0]) begin
            owned_t_q <= 1'b1;
        end else if (!tms_in) begin
            owned_t_q <= 1'b1;
        end else if (tap_next(tap_q, tms_in) == sxj_pkg::TAP_RESET) begin
            owned_t_q <= 1'b0;
        end
    end

    // checksum runs while selected and out of idle/reset
    assign cks_run = ir_q == sxj_pkg::IR_CHECKSUM
                     && tap_q != sxj_pkg::TAP_RESET
                     && tap_q != sxj_pkg::TAP_IDLE;

    // tdo pad on falling tck: scan data, checksum, or user pin
    always_ff @(negedge tck_in) begin
        if (!tck_rst_b) begin
            tdo_out <= 1'b0;
            tdo_oe_b_out <= 1'b1;
        end else if (cks_run) begin
            tdo_out <= dr_sh_q[0];
            tdo_oe_b_out <= 1'b0;
        end else if (owned_t_q || !tms_in) begin
            tdo_out <= (tap_q == sxj_pkg::TAP_SH_IR) ? ir_sh_q[0]
                                                     : dr_sh_q[0];
            tdo_oe_b_out <= ~(tap_q == sxj_pkg::TAP_SH_IR
                              || tap_q == sxj_pkg::TAP_SH_DR);
        end else begin
            tdo_out <= user_tdo_t[0];
            tdo_oe_b_out <= user_tdo_t[1];
        end
    end

    // clk domain
    // pins and tck-domain state into the clk domain
    sxj_sync2 #(.WIDTH(2)) u_strap (
        .clk_in(clk_in),
        .d_in({trst_reserve_in, dedicated_mode_in}),
        .q_out(strap_s)
    );
    sxj_sync2 #(.WIDTH(4)) u_pins (
        .clk_in(clk_in),
        .d_in({trst_in, tdo_in, tdi_in, tck_in}),
        .q_out(pin_s)
    );
    sxj_sync2 #(.WIDTH(4)) u_tstat (
        .clk_in(clk_in),
        .d_in({tms_in, cks_run, tap_q == sxj_pkg::TAP_RESET, owned_t_q}),
        .q_out(tck_stat_s)
    );

    // straps caught once after reset, frozen until next reset
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            cfg_done_q <= 1'b0;
            dedicated_q <= 1'b0;
            trst_res_q <= 1'b0;
        end else if (!cfg_done_q) begin
            cfg_done_q <= 1'b1;
            dedicated_q <= strap_s[0];
            trst_res_q <= strap_s[1];
        end
    end

    // pin ownership seen by the user pins
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            own_q <= 1'b0;
        end else begin
            own_q <= dedicated_q || !tck_stat_s[3]
                     || tck_stat_s[0];
        end
    end

    // control and lock registers; lock only ever sets
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            ctrl_q <= sxj_pkg::CTRL_RESET;
        end else if (reg_wr_in && reg_addr_in == sxj_pkg::REG_CTRL) begin
            ctrl_q <= reg_wdata_in;
        end
    end
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            kill_q <= 1'b0;
        end else if (reg_wr_in && reg_addr_in == sxj_pkg::REG_LOCK
                     && reg_wdata_in[sxj_pkg::LOCK_KILL]) begin
            kill_q <= 1'b1;
        end
    end
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            user_q <= sxj_pkg::USER_RESET;
        end else if (reg_wr_in && reg_addr_in == sxj_pkg::REG_USER) begin
            user_q <= reg_wdata_in;
        end
    end

    // read data one cycle after the strobe, zero elsewhere
    always_ff @(posedge clk_in) begin
        if (!rst_b_in || !reg_rd_in) begin
            reg_rdata_out <= 32'h0000_0000;
        end else if (reg_addr_in == sxj_pkg::REG_CTRL) begin
            reg_rdata_out <= ctrl_q;
        end else if (reg_addr_in == sxj_pkg::REG_LOCK) begin
            reg_rdata_out <= {31'h0000_0000, kill_q};
        end else if (reg_addr_in == sxj_pkg::REG_USER) begin
            reg_rdata_out <= user_q;
        end else if (reg_addr_in == sxj_pkg::REG_STATUS) begin
            reg_rdata_out <= {26'h000_0000, kill_q, trst_res_q,
                              dedicated_q, tck_stat_s[2],
                              tck_stat_s[1], own_q};
        end else if (reg_addr_in == sxj_pkg::REG_PINS) begin
            reg_rdata_out <= {28'h000_0000, pin_s};
        end else begin
            reg_rdata_out <= 32'h0000_0000;
        end
    end

    // tck and tdi pads: released while owned, else user
    always_ff @(posedge clk_in) begin
        if (!rst_b_in || own_q) begin
            tck_out <= 1'b0;
            tck_oe_b_out <= 1'b1;
            tdi_out <= 1'b0;
            tdi_oe_b_out <= 1'b1;
        end else begin
            tck_out <= user_q[sxj_pkg::PIN_TCK];
            tck_oe_b_out <= user_q[sxj_pkg::USER_OE_LSB + sxj_pkg::PIN_TCK];
            tdi_out <= user_q[sxj_pkg::PIN_TDI];
            tdi_oe_b_out <= user_q[sxj_pkg::USER_OE_LSB + sxj_pkg::PIN_TDI];
        end
    end

    // trst pad: input with pull-up when reserved, else user pin
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            trst_out <= 1'b0;
            trst_oe_b_out <= 1'b1;
            trst_pullup_out <= 1'b1;
        end else if (trst_res_q) begin
            trst_out <= 1'b0;
            trst_oe_b_out <= 1'b1;
            trst_pullup_out <= 1'b1;
        end else begin
            trst_out <= user_q[sxj_pkg::PIN_TRST];
            trst_oe_b_out <= user_q[sxj_pkg::USER_OE_LSB
                                    + sxj_pkg::PIN_TRST];
            trst_pullup_out <= 1'b0;
        end
    end

    // ownership flag for the core
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            pins_owned_out <= 1'b0;
        end else begin
            pins_owned_out <= own_q;
        end
    end

    // probe stage controls
    assign pif.sel_a = ctrl_q[sxj_pkg::CTRL_SEL_A_LSB +: sxj_pkg::SEL_W];
    assign pif.sel_b = ctrl_q[sxj_pkg::CTRL_SEL_B_LSB +: sxj_pkg::SEL_W];
    assign pif.user_a = ctrl_q[sxj_pkg::CTRL_USER_A];
    assign pif.user_b = ctrl_q[sxj_pkg::CTRL_USER_B];
    assign pif.kill = kill_q;
    assign pif.user_val = user_q[sxj_pkg::PIN_PB:sxj_pkg::PIN_PA];
    assign pif.user_oe_b = user_q[sxj_pkg::USER_OE_LSB + sxj_pkg::PIN_PB:
                                  sxj_pkg::USER_OE_LSB + sxj_pkg::PIN_PA];

    sxj_probe_stage #(.NODES(NODES)) u_probe (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .nodes_in(probe_nodes_in),
        .pif(pif.stage),
        .pa_out(probe_out_a_out),
        .pa_oe_b_out(probe_out_a_oe_b_out),
        .pb_out(probe_out_b_out),
        .pb_oe_b_out(probe_out_b_oe_b_out)
    );
endmodule
`default_nettype wire

//--- tb/sxj_pin_ctrl_props.sv
// checker on the pin controller's top ports.
// assumes straps change only under reset.
`timescale 1ns/100ps
`default_nettype none
module sxj_pin_ctrl_props #(
    parameter int NODES = 16
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic tms_in,
    input wire logic trst_in,
    input wire logic dedicated_mode_in,
    input wire logic trst_reserve_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [NODES-1:0] probe_nodes_in,
    input wire logic [31:0] reg_rdata_out,
    input wire logic tck_oe_b_out,
    input wire logic tdi_oe_b_out,
    input wire logic trst_out,
    input wire logic trst_oe_b_out,
    input wire logic trst_pullup_out,
    input wire logic probe_out_a_out,
    input wire logic probe_out_a_oe_b_out,
    input wire logic pins_owned_out
);
    logic [9:0] ctrl_q;
    logic [13:0] user_q;
    logic kill_q;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    // mirror of pin writes
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            ctrl_q <= 10'h000;
            user_q <= 14'h3f00;
        end else if (reg_wr_in && reg_addr_in == sxj_pkg::REG_CTRL) begin
            ctrl_q <= reg_wdata_in[9:0];
        end else if (reg_wr_in && reg_addr_in == sxj_pkg::REG_USER) begin
            user_q <= reg_wdata_in[13:0];
        end
    end
    // sticky probe disable
    always_ff @(posedge clk_in) begin
        if (!rst_b_in)
            kill_q <= 1'b0;
        else if (reg_wr_in && reg_addr_in == sxj_pkg::REG_LOCK)
            kill_q <= kill_q | reg_wdata_in[0];
    end
    property p_claim;
        (!dedicated_mode_in && !tms_in && (trst_in || !trst_reserve_in))[*2]
            |-> ##[0:8] pins_owned_out;
    endproperty
    a_claim: assert property (p_claim) else $error("pins not claimed");
    property p_hold;
        pins_owned_out[*3] |-> tck_oe_b_out && tdi_oe_b_out;
    endproperty
    a_hold: assert property (p_hold) else $error("owned pin driven");
    property p_trst;
        (!dedicated_mode_in && trst_reserve_in && !trst_in && tms_in)[*2]
            |-> ##[0:8] !pins_owned_out;
    endproperty
    a_trst: assert property (p_trst) else $error("trst ignored");
    property p_pull;
        trst_reserve_in[*6] |-> trst_pullup_out && trst_oe_b_out;
    endproperty
    a_pull: assert property (p_pull) else $error("trst pull-up off");
    property p_trst_user;
        (!trst_reserve_in && $stable(user_q))[*6] |->
            trst_oe_b_out == user_q[sxj_pkg::USER_OE_LSB + sxj_pkg::PIN_TRST]
            && (trst_oe_b_out || trst_out == user_q[sxj_pkg::PIN_TRST]);
    endproperty
    a_trst_user: assert property (p_trst_user) else $error("trst user");
    property p_node;
        (!kill_q && !ctrl_q[8] && $stable(ctrl_q) && $stable(probe_nodes_in))[*4]
            |-> probe_out_a_out == probe_nodes_in[ctrl_q[3:0]]
            && !probe_out_a_oe_b_out;
    endproperty
    a_node: assert property (p_node) else $error("probe node wrong");
    property p_user;
        (ctrl_q[8] && $stable(ctrl_q) && $stable(user_q))[*4] |->
            probe_out_a_oe_b_out == user_q[sxj_pkg::USER_OE_LSB + 4]
            && (probe_out_a_oe_b_out || probe_out_a_out == user_q[4]);
    endproperty
    a_user: assert property (p_user) else $error("probe user wrong");
    property p_kill;
        (kill_q && !ctrl_q[8] && $stable(ctrl_q))[*4] |-> !probe_out_a_out;
    endproperty
    a_kill: assert property (p_kill) else $error("probe not hidden");
    property p_status;
        $past(reg_rd_in) && $past(reg_addr_in) == sxj_pkg::REG_STATUS |->
            reg_rdata_out[sxj_pkg::ST_DEDICATED] == dedicated_mode_in
            && reg_rdata_out[sxj_pkg::ST_TRST_RES] == trst_reserve_in;
    endproperty
    a_status: assert property (p_status) else $error("strap status");
endmodule
`default_nettype wire

//--- tb/sxj_tester.sv
// scan tester model on the shared pins.
// assumes one step call per tck; tck rests low.
`timescale 1ns/100ps
`default_nettype none
module sxj_tester (
    input wire logic tdo_in,
    output logic tck_out,
    output logic tms_out,
    output logic tdi_out
);
    // idle: tck still, tms high
    initial begin
        tck_out = 1'b0;
        tms_out = 1'b1;
        tdi_out = 1'b0;
    end
    // one tck period, tdo read first
    task automatic step(input logic m, input logic d, output logic o);
        o = tdo_in;
        tms_out = m;
        tdi_out = d;
        #15 tck_out = 1'b1;
        #14 tck_out = 1'b0;
        #1 tdi_out = ~d; // no stale bit
    endtask
endmodule
`default_nettype wire

//--- tb/sxj_pin_ctrl_tb.sv
// bench for the shared test pin controller.
// assumes tester and checker compiled first.
`timescale 1ns/100ps
`default_nettype none
module sxj_pin_ctrl_tb;
    localparam logic [31:0] CSUM = 32'h0000_5a3c;
    logic clk_in = 1'b0, rst_b_in = 1'b0, trst_drv = 1'b1;
    logic dedicated_mode_in = 1'b0, trst_reserve_in = 1'b1;
    logic [7:0] reg_addr_in = 8'h00;
    logic [31:0] reg_wdata_in = 32'h0, reg_rdata_out, v;
    logic reg_wr_in = 1'b0, reg_rd_in = 1'b0;
    logic [15:0] probe_nodes_in = 16'h0000;
    logic tck_out, tck_oe_b_out, tdi_out, tdi_oe_b_out, tdo_out;
    logic tdo_oe_b_out, trst_out, trst_oe_b_out, trst_pullup_out;
    logic pa, pa_oe_b, pb, pb_oe_b, pins_owned_out;
    wire logic tck_in, tms_in, tdi_in, tdo_in, trst_in;
    int mismatches = 0;
    int cmp_count = 0;
    // clock and pad levels
    always #20 clk_in = ~clk_in;
    assign tdo_in = tdo_oe_b_out ? ~tdo_out : tdo_out;
    assign trst_in = trst_oe_b_out ? trst_drv : trst_out;
    sxj_tester i_tester (.tdo_in(tdo_in), .tck_out(tck_in),
        .tms_out(tms_in), .tdi_out(tdi_in));
    sxj_pin_ctrl #(.CHECKSUM_VALUE(CSUM)) i_dut (.clk_in, .rst_b_in,
        .tck_in, .tms_in, .tdi_in, .tdo_in, .trst_in, .dedicated_mode_in,
        .trst_reserve_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
        .reg_rd_in, .probe_nodes_in, .reg_rdata_out, .tck_out,
        .tck_oe_b_out, .tdi_out, .tdi_oe_b_out, .tdo_out, .tdo_oe_b_out,
        .trst_out, .trst_oe_b_out, .trst_pullup_out,
        .probe_out_a_out(pa), .probe_out_a_oe_b_out(pa_oe_b),
        .probe_out_b_out(pb), .probe_out_b_oe_b_out(pb_oe_b),
        .pins_owned_out);
    // verdict and end of run
    task automatic summarize;
        if (mismatches == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // one comparison
    task automatic chk(input string nm, input logic [31:0] e,
            input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    // register port write and read
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        @(negedge clk_in);
        d = reg_rdata_out;
    endtask
    task automatic settle;
        repeat (10) @(posedge clk_in);
    endtask
    // tms walk and shift, lsb first
    task automatic seq(input logic [7:0] t, input int n);
        logic o;
        for (int i = 0; i < n; i++) i_tester.step(t[i], 1'b0, o);
    endtask
    task automatic shift(input int n, input logic [31:0] d,
            output logic [31:0] g);
        logic o;
        g = 32'h0;
        for (int i = 0; i < n; i++) begin
            i_tester.step(i == n - 1, d[i], o);
            g[i] = o;
        end
    endtask
    // reset with straps, tck pulsed around it
    task automatic do_reset(input logic d, input logic r);
        logic o;
        @(posedge clk_in);
        rst_b_in <= 1'b0;
        dedicated_mode_in <= d;
        trst_reserve_in <= r;
        repeat (4) i_tester.step(1'b1, 1'b0, o);
        repeat (12) @(posedge clk_in);
        rst_b_in <= 1'b1;
        repeat (2) i_tester.step(1'b1, 1'b0, o); // tck sync out of reset
        settle;
    endtask
    // watchdog
    initial begin
        #2000000;
        mismatches++;
        summarize();
    end
    // main sequence
    initial begin
        do_reset(1'b0, 1'b1);
        rd(sxj_pkg::REG_STATUS, v);
        chk("status", 32'h12, v);
        chk("trst_pull", 32'h3, {trst_pullup_out, trst_oe_b_out});
        seq(8'h06, 5);
        shift(4, {28'h0, sxj_pkg::IR_CHECKSUM}, v);
        seq(8'h05, 5);
        settle;
        chk("owned", 32'h7, {pins_owned_out, tck_oe_b_out, tdi_oe_b_out});
        chk("tdo_oe_b", 32'h0, tdo_oe_b_out);
        shift(32, 32'h0, v);
        chk("checksum", CSUM, v);
        seq(8'h03, 2);
        settle;
        chk("owned", 32'h1, pins_owned_out);
        seq(8'h07, 3);
        settle;
        chk("release", 32'h1, {pins_owned_out, tdo_oe_b_out});
        seq(8'h02, 2);
        settle;
        @(posedge clk_in) trst_drv <= 1'b0;
        settle;
        chk("trst_reset", 32'h0, pins_owned_out);
        @(posedge clk_in) trst_drv <= 1'b1;
        wr(sxj_pkg::REG_CTRL, 32'h53);
        @(posedge clk_in) probe_nodes_in <= 16'h0028;
        settle;
        chk("probe", 32'hc, {pb, pa, pb_oe_b, pa_oe_b});
        @(posedge clk_in) probe_nodes_in <= 16'h0010;
        settle;
        chk("probe", 32'h0, {pb, pa, pb_oe_b, pa_oe_b});
        wr(sxj_pkg::REG_USER, 32'h2f10);
        wr(sxj_pkg::REG_CTRL, 32'h353);
        settle;
        chk("probe_user", 32'h6, {pb, pa, pb_oe_b, pa_oe_b});
        wr(sxj_pkg::REG_LOCK, 32'h1);
        wr(sxj_pkg::REG_CTRL, 32'h53);
        @(posedge clk_in) probe_nodes_in <= 16'h0028;
        settle;
        chk("probe_kill", 32'h0, {pb, pa});
        rd(sxj_pkg::REG_STATUS, v);
        chk("status", 32'h32, v);
        do_reset(1'b1, 1'b0);
        rd(sxj_pkg::REG_STATUS, v);
        chk("status", 32'h08, v & 32'h38);
        wr(sxj_pkg::REG_USER, 32'h3708);
        settle;
        chk("trst_user", 32'h1, {trst_oe_b_out, trst_out});
        rd(8'h20, v);
        chk("unmapped", 32'h0, v);
        summarize();
    end
endmodule
bind sxj_pin_ctrl sxj_pin_ctrl_props #(.NODES(NODES)) i_props (.clk_in,
    .rst_b_in, .tms_in, .trst_in, .dedicated_mode_in, .trst_reserve_in,
    .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .probe_nodes_in,
    .reg_rdata_out, .tck_oe_b_out, .tdi_oe_b_out, .trst_out,
    .trst_oe_b_out, .trst_pullup_out, .probe_out_a_out,
    .probe_out_a_oe_b_out, .pins_owned_out);
`default_nettype wire
